// ### core/sbla_loader.sv
// Boot-mode entry, bit-rate alignment, flash blanking and RAM download of the boot loader.
// Operation
// - After reset in boot mode, measure host low period and set divisor.
// - Frames are 8N1; the measured low interval spans nine bit times.
// - After alignment send exactly one zero byte.
// - Program goes to a 0xC00-byte RAM window chosen by mode.
// - A 0x3F0-byte RAM area is reserved for the loader itself.
// - After download jump to the high address in mode 7, else the low one; the load window goes high in mode 6.
// - Wait about 100 states after reset before measuring the low period.
// - If flash is not blank, erase every block first.
// - Before the jump clear receive and transmit enables, keep the divisor.
// - At the jump the transmit line drives high, direction and level bits set.
// - Boot mode is latched at reset release and kept until external reset.
// - Watchdog reset keeps boot mode and restarts the loader regardless of pins.
// - With 12 V on program voltage a watchdog overflow drives no reset out.
`timescale 1ns/100ps
`default_nettype none
module sbla_fifo #(
    parameter int unsigned W = 8,
    parameter int unsigned D = 4
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic clr_in,
    input wire logic [W-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    output logic [W-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);
    localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;
    logic [W-1:0] mem_r [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;
    assign wr_ready_out = (cnt_r != (AW+1)'(D));
    assign rd_valid_out = (cnt_r != '0);
    assign rd_data_out = mem_r[rp_r];
    assign push = wr_valid_in && wr_ready_out;
    assign pop = rd_valid_out && rd_ready_in;
    always_ff @(posedge mclk_in) begin
        if (push) begin
            mem_r[wp_r] <= wr_data_in;
        end
    end
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else if (clr_in) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

module sbla_loader #(
    parameter int unsigned DIV_W = 17,
    parameter int unsigned FIFO_DEPTH = 4
) (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire logic wdt_rst_in,
    input wire logic vpp_12v_in,
    input wire logic mode_select_high_pin_12v_in,
    input wire logic mode_select_high_pin_in,
    input wire logic mode_select_mid_pin_in,
    input wire logic mode_select_low_pin_in,
    input wire logic boot_receive_line_in,
    output logic boot_transmit_line_out,
    input wire logic flash_all_erased_in,
    output logic flash_erase_req_out,
    input wire logic flash_erase_done_in,
    output logic ram_wr_out,
    output logic [23:0] ram_addr_out,
    output logic [7:0] ram_data_out,
    input wire logic ram_ready_in,
    output logic boot_mode_out,
    output logic user_program_mode_out,
    output logic [1:0] op_mode_out,
    output logic [23:0] work_ram_base_out,
    output logic receive_enable_bit_out,
    output logic transmit_enable_bit_out,
    output logic [DIV_W-1:0] bit_rate_divisor_register_out,
    output logic port_nine_direction_out,
    output logic transmit_pin_output_level_bit_out,
    output logic jump_out,
    output logic [23:0] jump_addr_out,
    input wire logic watchdog_reset_output_enable_in,
    input wire logic wdt_overflow_in,
    output logic wdt_reset_out,
    output logic rx_overrun_out,
    output sbla_pkg::sbla_state_t boot_state_out
);
    import sbla_pkg::*;

    logic [5:0] pin_s1_r;
    logic [5:0] pin_s2_r;
    logic rxd;
    logic [1:0] cap_cnt_r;
    logic boot_r;
    logic user_r;
    logic [1:0] mode_r;
    logic restart;
    sbla_state_t state_r;
    logic [6:0] settle_r;
    logic [DIV_W+3:0] low_cnt_r;
    logic [3:0] pre_r;
    logic [DIV_W-1:0] div_r;
    logic re_r;
    logic te_r;
    logic dir_r;
    logic lvl_r;
    logic [23:0] addr_r;
    logic [11:0] loaded_r;
    logic [23:0] jaddr_r;
    logic rx_busy_r;
    logic [DIV_W-1:0] rx_tmr_r;
    logic [3:0] rx_bit_r;
    logic [7:0] rx_sh_r;
    logic rx_valid_r;
    logic [7:0] rx_byte_r;
    logic hold_v_r;
    logic [7:0] hold_r;
    logic ovr_r;
    logic fifo_ready;
    logic fifo_valid;
    logic [7:0] fifo_data;
    logic tx_go;
    logic tx_busy_r;
    logic [DIV_W-1:0] tx_tmr_r;
    logic [3:0] tx_cnt_r;
    logic [9:0] tx_sh_r;
    logic tx_line_r;
    logic pop;

    // Pins are asynchronous; only the second stage is looked at.
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pin_s1_r <= 6'h3f;
            pin_s2_r <= 6'h3f;
        end else begin
            pin_s1_r <= {boot_receive_line_in, vpp_12v_in, mode_select_high_pin_12v_in,
                         mode_select_high_pin_in, mode_select_mid_pin_in,
                         mode_select_low_pin_in};
            pin_s2_r <= pin_s1_r;
        end
    end
    assign rxd = pin_s2_r[5];

    // Mode is caught once the synchronised pins are valid after release; only the
    // external reset clears it, so later pin changes and watchdog resets leave it.
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cap_cnt_r <= 2'h0;
            boot_r <= 1'b0;
            user_r <= 1'b0;
            mode_r <= 2'h0;
        end else if (cap_cnt_r != 2'h3) begin
            cap_cnt_r <= cap_cnt_r + 2'h1;
            if (cap_cnt_r == 2'h2) begin
                mode_r <= pin_s2_r[1:0];
                boot_r <= pin_s2_r[4] && pin_s2_r[3] && (pin_s2_r[1:0] != 2'h0);
                user_r <= pin_s2_r[4] && !pin_s2_r[3] && pin_s2_r[2]
                          && (pin_s2_r[1:0] != 2'h0);
            end
        end
    end

    assign restart = wdt_rst_in && (cap_cnt_r == 2'h3);
    assign tx_go = (state_r == ST_SEND_ACK);
    assign pop = fifo_valid && ram_ready_in && (state_r == ST_LOAD);

    // Loader sequence.
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_r <= ST_IDLE;
            settle_r <= 7'h00;
            low_cnt_r <= '0;
            pre_r <= 4'h0;
            div_r <= '0;
            re_r <= 1'b0;
            te_r <= 1'b0;
            dir_r <= 1'b0;
            lvl_r <= 1'b0;
            addr_r <= 24'h00_0000;
            loaded_r <= 12'h000;
            jaddr_r <= 24'h00_0000;
        end else if (restart) begin
            state_r <= boot_r ? ST_SETTLE : ST_IDLE;
            settle_r <= 7'h00;
            re_r <= 1'b0;
            te_r <= 1'b0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (cap_cnt_r == 2'h3 && boot_r) begin
                        state_r <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    settle_r <= settle_r + 7'h01;
                    if (settle_r == 7'(SETTLE_CYC - 1)) begin
                        state_r <= ST_WAIT_LOW;
                    end
                end
                ST_WAIT_LOW: begin
                    if (!rxd) begin
                        state_r <= ST_MEASURE;
                        low_cnt_r <= (DIV_W+4)'(1);
                        pre_r <= 4'(ROUND_HALF + 1);
                        div_r <= '0;
                    end
                end
                ST_MEASURE: begin
                    if (!rxd) begin
                        // Each nine cycles of low add one to the cycles-per-bit count.
                        low_cnt_r <= low_cnt_r + 1'b1;
                        if (pre_r == 4'(MEASURE_BITS - 1)) begin
                            pre_r <= 4'h0;
                            div_r <= div_r + 1'b1;
                        end else begin
                            pre_r <= pre_r + 4'h1;
                        end
                    end else begin
                        // A glitch too short to give a usable bit time is discarded.
                        state_r <= (div_r == '0) ? ST_WAIT_LOW : ST_SEND_ACK;
                        te_r <= (div_r != '0);
                    end
                end
                ST_SEND_ACK: begin
                    state_r <= ST_ACK_WAIT;
                end
                ST_ACK_WAIT: begin
                    if (!tx_busy_r) begin
                        state_r <= ST_WAIT_SYNC;
                        re_r <= 1'b1;
                    end
                end
                ST_WAIT_SYNC: begin
                    if (rx_valid_r && rx_byte_r == SYNC_BYTE) begin
                        state_r <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    state_r <= flash_all_erased_in ? ST_LOAD : ST_ERASE;
                    addr_r <= (mode_r == MODE6) ? LOAD_BASE_HIGH : LOAD_BASE_LOW;
                    loaded_r <= 12'h000;
                end
                ST_ERASE: begin
                    if (flash_erase_done_in) begin
                        state_r <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    if (pop) begin
                        addr_r <= addr_r + 24'h00_0001;
                        loaded_r <= loaded_r + 12'h001;
                        if (loaded_r == LOAD_BYTES - 12'h001) begin
                            state_r <= ST_JUMP;
                            re_r <= 1'b0;
                            te_r <= 1'b0;
                            dir_r <= 1'b1;
                            lvl_r <= 1'b1;
                            jaddr_r <= (mode_r == MODE7) ? JUMP_HIGH : JUMP_LOW;
                        end
                    end
                end
                ST_JUMP: begin
                    state_r <= ST_DONE;
                end
                ST_DONE: begin
                    state_r <= ST_DONE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Receiver, sampling mid-bit with the aligned divisor.
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rx_busy_r <= 1'b0;
            rx_tmr_r <= '0;
            rx_bit_r <= 4'h0;
            rx_sh_r <= 8'h00;
            rx_valid_r <= 1'b0;
            rx_byte_r <= 8'h00;
        end else begin
            rx_valid_r <= 1'b0;
            if (!re_r) begin
                rx_busy_r <= 1'b0;
            end else if (!rx_busy_r) begin
                if (!rxd) begin
                    rx_busy_r <= 1'b1;
                    rx_tmr_r <= div_r >> 1;
                    rx_bit_r <= 4'h0;
                end
            end else if (rx_tmr_r != '0) begin
                rx_tmr_r <= rx_tmr_r - 1'b1;
            end else begin
                rx_tmr_r <= div_r - 1'b1;
                rx_bit_r <= rx_bit_r + 4'h1;
                if (rx_bit_r == 4'h0 && rxd) begin
                    rx_busy_r <= 1'b0;
                end else if (rx_bit_r == 4'h9) begin
                    // A byte whose stop bit is low is dropped as a framing error.
                    rx_busy_r <= 1'b0;
                    rx_valid_r <= rxd;
                    rx_byte_r <= rx_sh_r;
                end else if (rx_bit_r != 4'h0) begin
                    rx_sh_r <= {rxd, rx_sh_r[7:1]};
                end
            end
        end
    end

    // The serial link cannot be stalled, so a byte that finds the holding
    // register still waiting on a full FIFO is lost and flagged.
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            hold_v_r <= 1'b0;
            hold_r <= 8'h00;
            ovr_r <= 1'b0;
        end else if (restart) begin
            // A byte caught before a watchdog restart must not leak into the next load.
            hold_v_r <= 1'b0;
        end else begin
            if (hold_v_r && fifo_ready) begin
                hold_v_r <= 1'b0;
            end
            if (rx_valid_r && state_r == ST_LOAD) begin
                if (hold_v_r && !fifo_ready) begin
                    ovr_r <= 1'b1;
                end else begin
                    hold_v_r <= 1'b1;
                    hold_r <= rx_byte_r;
                end
            end
        end
    end

    sbla_fifo #(
        .W(8),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .clr_in(restart),
        .wr_data_in(hold_r),
        .wr_valid_in(hold_v_r),
        .wr_ready_out(fifo_ready),
        .rd_data_out(fifo_data),
        .rd_valid_out(fifo_valid),
        .rd_ready_in(pop)
    );

    // Transmitter; the only byte it ever sends is the alignment answer.
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tx_busy_r <= 1'b0;
            tx_tmr_r <= '0;
            tx_cnt_r <= 4'h0;
            tx_sh_r <= 10'h3ff;
            tx_line_r <= 1'b1;
        end else if (!tx_busy_r) begin
            tx_line_r <= 1'b1;
            if (tx_go) begin
                tx_busy_r <= 1'b1;
                tx_sh_r <= {1'b1, ACK_BYTE, 1'b0};
                tx_tmr_r <= div_r - 1'b1;
                tx_cnt_r <= 4'h0;
                tx_line_r <= 1'b0;
            end
        end else if (tx_tmr_r != '0) begin
            tx_tmr_r <= tx_tmr_r - 1'b1;
        end else if (tx_cnt_r == 4'h9) begin
            tx_busy_r <= 1'b0;
            tx_line_r <= 1'b1;
        end else begin
            tx_tmr_r <= div_r - 1'b1;
            tx_cnt_r <= tx_cnt_r + 4'h1;
            tx_sh_r <= {1'b1, tx_sh_r[9:1]};
            tx_line_r <= tx_sh_r[1];
        end
    end

    assign boot_transmit_line_out = tx_line_r;
    assign flash_erase_req_out = (state_r == ST_ERASE);
    assign ram_wr_out = pop;
    assign ram_addr_out = addr_r;
    assign ram_data_out = fifo_data;
    assign boot_mode_out = boot_r;
    assign user_program_mode_out = user_r;
    assign op_mode_out = mode_r;
    assign work_ram_base_out = (mode_r == MODE6) ? WORK_BASE_HIGH : WORK_BASE_LOW;
    assign receive_enable_bit_out = re_r;
    assign transmit_enable_bit_out = te_r;
    assign bit_rate_divisor_register_out = div_r;
    assign port_nine_direction_out = dir_r;
    assign transmit_pin_output_level_bit_out = lvl_r;
    assign jump_out = (state_r == ST_JUMP);
    assign jump_addr_out = jaddr_r;
    // Program voltage at 12 V blocks the watchdog reset output entirely.
    assign wdt_reset_out = wdt_overflow_in && watchdog_reset_output_enable_in
                           && !pin_s2_r[4];
    assign rx_overrun_out = ovr_r;
    assign boot_state_out = state_r;

    property p_wdt_gate;
        @(posedge mclk_in) disable iff (sys_rst_in)
        pin_s2_r[4] |-> !wdt_reset_out;
    endproperty
    a_wdt_gate: assert property (p_wdt_gate) else $error("watchdog reset under 12 V");

    property p_ack_zero;
        @(posedge mclk_in) disable iff (sys_rst_in)
        $rose(tx_busy_r) |-> tx_sh_r[8:1] == ACK_BYTE && $past(state_r) == ST_SEND_ACK;
    endproperty
    a_ack_zero: assert property (p_ack_zero) else $error("answer byte not zero");

    property p_div_round;
        @(posedge mclk_in) disable iff (sys_rst_in || restart)
        (state_r == ST_MEASURE && rxd) |->
            int'(div_r) == (int'(low_cnt_r) + ROUND_HALF) / MEASURE_BITS;
    endproperty
    a_div_round: assert property (p_div_round) else $error("divisor not rounded");

    property p_jump_quiet;
        @(posedge mclk_in) disable iff (sys_rst_in)
        jump_out |-> !re_r && !te_r && div_r == $past(div_r, 2) && div_r != '0;
    endproperty
    a_jump_quiet: assert property (p_jump_quiet) else $error("serial still on");

    property p_jump_high;
        @(posedge mclk_in) disable iff (sys_rst_in)
        jump_out |-> (dir_r && lvl_r && boot_transmit_line_out)[*4];
    endproperty
    a_jump_high: assert property (p_jump_high) else $error("transmit pin not high");

    property p_jump_addr;
        @(posedge mclk_in) disable iff (sys_rst_in)
        jump_out |-> jump_addr_out == ((mode_r == MODE7) ? JUMP_HIGH : JUMP_LOW);
    endproperty
    a_jump_addr: assert property (p_jump_addr) else $error("wrong jump address");

    property p_ram_window;
        @(posedge mclk_in) disable iff (sys_rst_in)
        ram_wr_out |-> ram_addr_out - ((mode_r == MODE6) ? LOAD_BASE_HIGH : LOAD_BASE_LOW)
                       < {12'h000, LOAD_BYTES};
    endproperty
    a_ram_window: assert property (p_ram_window) else $error("write outside window");

    property p_mode_kept;
        @(posedge mclk_in) disable iff (sys_rst_in)
        cap_cnt_r == 2'h3 |=> $stable(boot_r) && $stable(mode_r);
    endproperty
    a_mode_kept: assert property (p_mode_kept) else $error("latched mode changed");

    property p_wdt_restart;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (restart && boot_r) |=> state_r == ST_SETTLE && boot_r ##1 state_r == ST_SETTLE;
    endproperty
    a_wdt_restart: assert property (p_wdt_restart) else $error("no restart");

    property p_settle;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (state_r == ST_SETTLE && settle_r != 7'(SETTLE_CYC - 1) && !restart) |=>
            state_r == ST_SETTLE;
    endproperty
    a_settle: assert property (p_settle) else $error("settle too short");

    property p_erase;
        @(posedge mclk_in) disable iff (sys_rst_in || restart)
        (state_r == ST_CHECK) |=> (state_r == ST_ERASE) == !$past(flash_all_erased_in);
    endproperty
    a_erase: assert property (p_erase) else $error("erase decision wrong");
endmodule
`default_nettype wire

// ### core/sbla_pkg.sv
// Constants and state codes shared by the serial boot loader.
package sbla_pkg;
    // Settling time after reset release, in CPU states; one state is one clock.
    localparam int unsigned SETTLE_STATES = 100;
    localparam int unsigned STATES_PER_CLK = 1;
    localparam int unsigned SETTLE_CYC = SETTLE_STATES / STATES_PER_CLK;
    localparam int unsigned MEASURE_BITS = 9;
    localparam int unsigned ROUND_HALF = MEASURE_BITS / 2;
    localparam logic [7:0] ACK_BYTE = 8'h00;
    localparam logic [7:0] SYNC_BYTE = 8'h55;
    localparam logic [11:0] LOAD_BYTES = 12'h0c00;
    localparam logic [11:0] WORK_BYTES = 12'h03f0;
    localparam logic [23:0] LOAD_BASE_LOW = 24'h0f_f300;
    localparam logic [23:0] LOAD_BASE_HIGH = 24'hff_f300;
    localparam logic [23:0] WORK_BASE_LOW = 24'h0f_ef10;
    localparam logic [23:0] WORK_BASE_HIGH = 24'hff_ef10;
    localparam logic [23:0] JUMP_LOW = 24'h0f_f300;
    localparam logic [23:0] JUMP_HIGH = 24'hff_f300;
    localparam logic [1:0] MODE5 = 2'h1;
    localparam logic [1:0] MODE6 = 2'h2;
    localparam logic [1:0] MODE7 = 2'h3;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_SETTLE = 4'b0001,
        ST_WAIT_LOW = 4'b0010,
        ST_MEASURE = 4'b0011,
        ST_SEND_ACK = 4'b0100,
        ST_ACK_WAIT = 4'b0101,
        ST_WAIT_SYNC = 4'b0110,
        ST_CHECK = 4'b0111,
        ST_ERASE = 4'b1000,
        ST_LOAD = 4'b1001,
        ST_JUMP = 4'b1010,
        ST_DONE = 4'b1011
    } sbla_state_t;
endpackage

// ### verif/sbla_host.sv
// Host-side serial model that talks to the boot loader over the 8N1 link.
`timescale 1ns/100ps
`default_nettype none
module sbla_host (
    input wire logic mclk_in,
    input wire logic dev_tx_in,
    output logic host_tx_out
);
    initial host_tx_out = 1'b1;
    // Frames go out LSB first and change only on the falling edge.
    task automatic send_byte(input logic [7:0] b, input int bc);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            host_tx_out = f[i];
            repeat (bc) @(negedge mclk_in);
        end
    endtask
    task automatic get_byte(input int bc, output logic [7:0] b, output bit ok);
        int n;
        n = 0;
        while (dev_tx_in !== 1'b0 && n < 4000) begin
            @(negedge mclk_in);
            n++;
        end
        ok = (n < 4000);
        repeat (bc / 2) @(negedge mclk_in);
        for (int i = 0; i < 8; i++) begin
            repeat (bc) @(negedge mclk_in);
            b[i] = dev_tx_in;
        end
        repeat (bc) @(negedge mclk_in);
        ok = ok && (dev_tx_in === 1'b1);
    endtask
endmodule
`default_nettype wire

// ### verif/sbla_loader_test.sv
// Self-checking bench for the boot loader: alignment, download, jump and resets.
`timescale 1ns/100ps
`default_nettype none
module sbla_loader_test;
    import sbla_pkg::*;
    // Bit time is scaled far below the host rates to fit the cycle budget; alignment
    // only counts clocks, so the divisor path is the same at any rate.
    localparam int BC = 3;
    logic mclk_in = 0, sys_rst_in = 1, wdt_rst_in = 0, vpp = 1, hv = 1, md2 = 0, mid = 0;
    logic low = 1, rx, tx, erased = 0, ers_req, ers_done = 0, wr, rdy = 1, bm, um, jmp;
    logic re, te, dir, lvl, watchdog_reset_output_enable = 1, ovf = 0, wrst, ovr, stall = 0;
    logic [1:0] om;
    logic [23:0] addr, wbase, jaddr;
    logic [7:0] data;
    logic [16:0] div;
    sbla_state_t st;
    int error_cnt = 0, checks_done = 0, nwr = 0;
    logic [7:0] exp_q[$];
    sbla_host host (.mclk_in(mclk_in), .dev_tx_in(tx), .host_tx_out(rx));
    sbla_loader uut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .wdt_rst_in(wdt_rst_in),
        .vpp_12v_in(vpp), .mode_select_high_pin_12v_in(hv), .mode_select_high_pin_in(md2),
        .mode_select_mid_pin_in(mid), .mode_select_low_pin_in(low),
        .boot_receive_line_in(rx), .boot_transmit_line_out(tx), .flash_all_erased_in(erased),
        .flash_erase_req_out(ers_req), .flash_erase_done_in(ers_done), .ram_wr_out(wr),
        .ram_addr_out(addr), .ram_data_out(data), .ram_ready_in(rdy), .boot_mode_out(bm),
        .user_program_mode_out(um), .op_mode_out(om), .work_ram_base_out(wbase),
        .receive_enable_bit_out(re), .transmit_enable_bit_out(te),
        .bit_rate_divisor_register_out(div), .port_nine_direction_out(dir),
        .transmit_pin_output_level_bit_out(lvl), .jump_out(jmp), .jump_addr_out(jaddr),
        .watchdog_reset_output_enable_in(watchdog_reset_output_enable), .wdt_overflow_in(ovf),
        .wdt_reset_out(wrst), .rx_overrun_out(ovr), .boot_state_out(st));
    initial forever #4 mclk_in = ~mclk_in;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_of_test;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    function automatic int exp_div(int bc);
        return (9 * bc + 4) / 9;
    endfunction
    // The RAM side stalls at random, and solidly while the FIFO is meant to fill.
    always @(negedge mclk_in) rdy <= stall ? 1'b0 : ($urandom_range(0, 3) != 0);
    always @(posedge mclk_in) begin
        if (wr === 1'b1) begin
            chk("ram_addr", 32'(LOAD_BASE_LOW) + nwr, {8'h00, addr});
            chk("ram_data", {24'h0000_00, exp_q.pop_front()}, {24'h0000_00, data});
            nwr++;
        end
    end
    initial begin
        #790_000;
        error_cnt++;
        end_of_test();
    end
    initial begin
        logic [7:0] b;
        bit ok;
        int n;
        void'($urandom(18066));
        repeat (3) @(negedge mclk_in);
        sys_rst_in = 0;
        repeat (12) @(negedge mclk_in);
        hv = 0;
        repeat (150) @(negedge mclk_in);
        chk("boot_mode", {29'h0, 1'b1, MODE5}, {29'h0, bm, om});
        chk("work_base", {8'h00, WORK_BASE_LOW}, {8'h00, wbase});
        chk("state", ST_WAIT_LOW, st);
        fork
            host.send_byte(8'h00, BC);
            host.get_byte(BC, b, ok);
        join
        chk("divisor", exp_div(BC), {15'h0, div});
        chk("ack", {23'h0, 1'b1, ACK_BYTE}, {23'h0, ok, b});
        // The receiver only opens once the answer's stop bit is out, so the host waits.
        repeat (2 * BC) @(negedge mclk_in);
        host.send_byte(SYNC_BYTE, BC);
        for (n = 0; n < 300 && ers_req !== 1'b1; n++) @(negedge mclk_in);
        chk("erase_req", 1, {31'h0, ers_req});
        ers_done = 1;
        @(negedge mclk_in);
        ers_done = 0;
        for (int i = 0; i < 3072; i++) begin
            b = 8'($urandom);
            exp_q.push_back(b);
            stall = (i >= 100 && i < 104);
            host.send_byte(b, BC);
        end
        for (n = 0; n < 400 && jmp !== 1'b1; n++) @(negedge mclk_in);
        chk("jump", {8'h01, JUMP_LOW}, {7'h0, jmp, jaddr});
        repeat (2) @(negedge mclk_in);
        chk("exit_pins", 32'h0000_0007, {27'h0, re, te, dir, lvl, tx});
        chk("divisor_kept", exp_div(BC), {15'h0, div});
        chk("writes", 3072, nwr);
        chk("overrun", 0, {31'h0, ovr});
        ovf = 1;
        @(negedge mclk_in);
        chk("wdt_reset", 0, {31'h0, wrst});
        vpp = 0;
        repeat (3) @(negedge mclk_in);
        chk("wdt_reset", 1, {31'h0, wrst});
        ovf = 0;
        wdt_rst_in = 1;
        @(negedge mclk_in);
        wdt_rst_in = 0;
        @(negedge mclk_in);
        chk("wdt_restart", {27'h1, ST_SETTLE}, {27'h0, bm, st});
        vpp = 1;
        md2 = 1;
        mid = 1;
        low = 0;
        sys_rst_in = 1;
        @(negedge mclk_in);
        sys_rst_in = 0;
        repeat (6) @(negedge mclk_in);
        chk("user_mode", {29'h0, 1'b1, MODE6}, {28'h0, bm, um, om});
        chk("work_base_m6", {8'h00, WORK_BASE_HIGH}, {8'h00, wbase});
        end_of_test();
    end
endmodule
`default_nettype wire
